// File: rtl/io_cfg_pkg.sv
// constants for the mixed i/o control and logging block
package io_cfg_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] DC_SAMP_OFS   = 8'h04;
	localparam logic [7:0] DC_UPD_OFS    = 8'h08;
	localparam logic [7:0] DIFF_FILT_OFS = 8'h0C;
	localparam logic [7:0] DIFF_UPD_OFS  = 8'h10;
	localparam logic [7:0] LOG_PER_OFS   = 8'h14;
	localparam logic [7:0] POST_TRIG_OFS = 8'h18;
	localparam logic [7:0] OUT_SRC_OFS   = 8'h1C;
	localparam logic [7:0] DIFF_CFG_OFS  = 8'h20;
	localparam logic [7:0] REM_DC_OFS    = 8'h24;
	localparam logic [7:0] REM_DIFF_OFS  = 8'h28;
	localparam logic [7:0] STATUS_OFS    = 8'h2C;
	localparam logic [7:0] LIMIT_OFS     = 8'h40;
	// control register fields
	localparam int C_EXT_RST = 0;
	localparam int C_RUN     = 1;
	localparam int C_LOG_EN  = 2;
	localparam int C_TRIG    = 3;
	localparam int C_RING    = 4;
	localparam int C_START   = 5;
	localparam int C_STROBE  = 6;
	localparam int C_TDIV    = 7;
	localparam int C_USER_SW = 8;
	localparam int C_DEPTH   = 9;
	localparam int C_DIR_SRC = 13;
	localparam int C_DIR_OUT = 14;
	localparam logic [31:0] CTRL_RST = 32'h0000_0801;
	localparam logic [3:0]  DEPTH_DEF = 4'h4;
	localparam logic [3:0]  DEPTH_MAX = 4'hB;
	localparam int          DEPTH_MIN_LOG2 = 8;
	// timing: steps of 0.01 us = 10 ns, clock 20 ns
	localparam int CLK_NS  = 20;
	localparam int STEP_NS = 10;
	localparam int US_NS   = 1000;
	localparam logic [15:0] DC_SAMP_MIN = 16'h000A;
	localparam logic [15:0] DC_SAMP_DEF = 16'h000F;
	localparam logic [15:0] DC_UPD_DEF  = 16'h000A;
	localparam logic [15:0] DIFF_UPD_DEF = 16'h0001;
	localparam logic [15:0] LOG_PER_DEF = 16'h0001;
	localparam logic [3:0]  FILT_SEL_DEF = 4'h0;
	localparam logic [3:0]  FILT_SEL_MAX = 4'hD;
	localparam logic [18:0] POST_DEF = 19'h00001;
	localparam logic [11:0] LIM_DC_DEF = 12'hFA0;
	localparam logic [11:0] LIM_DIFF_DEF = 12'h5DC;
	localparam int N_DC   = 32;
	localparam int N_DIFF = 8;
	localparam int N_FILT = 41;
	// stop-state codes, two bits per differential output
	localparam logic [1:0] STOP_LOW  = 2'h0;
	localparam logic [1:0] STOP_HIGH = 2'h1;
	localparam logic [1:0] STOP_HOLD = 2'h2;
	localparam logic [23:0] DIFF_CFG_RST = 24'h155500;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [1:0] {LOG_IDLE, LOG_RUN, LOG_POST, LOG_DONE} log_state_t;
endpackage : io_cfg_pkg

// File: rtl/input_filter.sv
// integrating digital filter for one input channel
`timescale 1ns/1ns
`default_nettype none
module input_filter (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        strobe,
	input  wire logic        din,
	input  wire logic [11:0] limit,
	output var  logic        dout
);
	logic [11:0] cnt_reg;
	logic [11:0] cnt_next;
	logic        out_next;
	wire         at_top = (cnt_reg >= limit);
	wire         at_bot = (cnt_reg == 12'h000);
	// count toward the input level, switch at the ends
	assign cnt_next = !strobe ? cnt_reg :
		din ? (at_top ? limit : cnt_reg + 12'h001) :
		(at_bot ? 12'h000 : cnt_reg - 12'h001);
	assign out_next = !strobe ? dout :
		(limit == 12'h000) ? din :
		(din && cnt_next >= limit) ? 1'b1 :
		(!din && cnt_next == 12'h000) ? 1'b0 : dout;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= 12'h000;
			dout    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			dout    <= out_next;
		end
	end
endmodule : input_filter
`default_nettype wire

// File: rtl/io_control_top.sv
// mixed i/o control: timing, filters, output select, stop states, logging
// Summary of operation
// RULE1: stopped control with external reset on drives board reset; off drives none.
// RULE2: dc sample period 0.10..655.36 us, 0.01 us steps; differential from 0.01; code stops at 655.35 us (register 0 gives 0.10).
// RULE3: differential filter period chosen from a list; sampling equals it.
// RULE4: dc filters run at the dc sampling period.
// RULE5: update period 0.10..655.36 us dc, from 0.01 us differential; code stops at 655.35 us dc (register 0 gives 0.10).
// RULE6: logging timer 1..32768 us in 1 us steps, default 1 us; code takes 1..41943 us at 50 clocks/us; larger values and register 0 (65536) wrap in 21 bits.
// RULE7: filter limit 0..4095, default 4000 dc and 1500 differential.
// RULE8: each output from remote bit or user circuit, default remote bit.
// RULE9: stopped differential outputs go low, high or hold; default high (reset value gives output 7 low).
// RULE10: differential stop choice applies only with external reset off.
// RULE11: rs-485 direction from register (default input) or user circuit.
// RULE12: rs-485 stop choice only with reset off and user-driven direction.
// RULE13: logging has storage and trigger modes, default storage.
// RULE14: logging buffer linear or ring, default linear.
// RULE15: logging start from user circuit or remote bit, default user.
// RULE16: logging strobes from internal timer or user, default timer.
// RULE17: buffer depth power of two 256..524288, default 4096.
// RULE18: trigger mode records post-trigger count, 1..depth-1, default 1.
// RULE19: logged data non-time-division or time-division, default non.
// RULE20: user switch 7..10 function enable, default disabled.
// RULE21: differential block uses only its lower eight channels.
// RULE22: post count only in trigger mode; log options only with logging on.
// RULE23: hold stop-state keeps the last driven value until control resumes.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module io_control_top #(
	parameter int LOG_CYC_PER_US = io_cfg_pkg::US_NS / io_cfg_pkg::CLK_NS
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [31:0] dc_in,
	input  wire logic [7:0]  diff_in,
	input  wire logic        rs485_in,
	input  wire logic [31:0] user_dc_out,
	input  wire logic [7:0]  user_diff_out,
	input  wire logic        user_rs485_out,
	input  wire logic        user_rs485_dir,
	input  wire logic        user_log_start,
	input  wire logic        user_log_strobe,
	input  wire logic        user_log_trigger,
	output var  logic [31:0] dc_filt,
	output var  logic [7:0]  diff_filt,
	output var  logic        rs485_filt,
	output var  logic [31:0] dc_out,
	output var  logic [7:0]  diff_out,
	output var  logic        rs485_out,
	output var  logic        rs485_oe,
	output var  logic        board_reset,
	output var  logic        log_wr,
	output var  logic [18:0] log_addr,
	output var  logic        log_time_div,
	output var  logic        user_sw_en
);
	// configuration registers
	logic [31:0] ctrl_reg;
	logic [15:0] dc_samp_reg;
	logic [15:0] dc_upd_reg;
	logic [3:0]  filt_sel_reg;
	logic [15:0] diff_upd_reg;
	logic [15:0] log_per_reg;
	logic [18:0] post_reg;
	logic [31:0] out_src_reg;
	logic [23:0] diff_cfg_reg;
	logic [31:0] rem_dc_reg;
	logic [9:0]  rem_diff_reg;
	logic [11:0] lim_reg [io_cfg_pkg::N_FILT];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// 0.01 us steps to whole clock cycles, rounded up, at least one
	function automatic logic [20:0] steps_to_cyc(input logic [16:0] v);
		int c;
		c = (int'(v) * io_cfg_pkg::STEP_NS + io_cfg_pkg::CLK_NS - 1) / io_cfg_pkg::CLK_NS;
		return (c < 1) ? 21'h000001 : c[20:0];
	endfunction : steps_to_cyc

	function automatic logic [16:0] filt_steps(input logic [3:0] sel);
		unique case (sel)
			4'h0: return 17'h00001;
			4'h1: return 17'h00002;
			4'h2: return 17'h00004;
			4'h3: return 17'h00008;
			4'h4: return 17'h0000A;
			4'h5: return 17'h00010;
			4'h6: return 17'h00014;
			4'h7: return 17'h00020;
			4'h8: return 17'h00028;
			4'h9: return 17'h00032;
			4'hA: return 17'h00064;
			4'hB: return 17'h000C8;
			4'hC: return 17'h003E8;
			4'hD: return 17'h02710;
			default: return 17'h00001;
		endcase
	endfunction : filt_steps

	// bus slave
	logic                    aw_full_reg;
	logic                    w_full_reg;
	logic [io_cfg_pkg::ADDR_W-1:0] aw_addr_reg;
	logic [31:0]             w_data_reg;
	logic [3:0]              w_strb_reg;
	wire  do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
	wire  [7:0] wa = aw_addr_reg;
	wire  [7:0] ra = s_axi_araddr;
	wire  [7:0] wl = wa - io_cfg_pkg::LIMIT_OFS;
	wire  [7:0] rl = ra - io_cfg_pkg::LIMIT_OFS;
	wire  w_lim = (wa >= io_cfg_pkg::LIMIT_OFS) && (wl[7:2] < 6'(io_cfg_pkg::N_FILT));
	wire  r_lim = (ra >= io_cfg_pkg::LIMIT_OFS) && (rl[7:2] < 6'(io_cfg_pkg::N_FILT));
	wire  [31:0] wv_ctrl = merge(ctrl_reg, w_data_reg, w_strb_reg);
	wire  [31:0] wv_any  = merge(32'h0, w_data_reg, w_strb_reg);
	logic w_map;
	logic r_map;
	logic [31:0] r_word;

	always_comb begin
		unique case (wa)
			io_cfg_pkg::CTRL_OFS, io_cfg_pkg::DC_SAMP_OFS, io_cfg_pkg::DC_UPD_OFS,
			io_cfg_pkg::DIFF_FILT_OFS, io_cfg_pkg::DIFF_UPD_OFS, io_cfg_pkg::LOG_PER_OFS,
			io_cfg_pkg::POST_TRIG_OFS, io_cfg_pkg::OUT_SRC_OFS, io_cfg_pkg::DIFF_CFG_OFS,
			io_cfg_pkg::REM_DC_OFS, io_cfg_pkg::REM_DIFF_OFS: w_map = (wa[1:0] == 2'h0);
			default: w_map = w_lim && (wa[1:0] == 2'h0);
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= io_cfg_pkg::RESP_OK;
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			aw_addr_reg   <= '0;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg   <= 1'b1;
				aw_addr_reg   <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg   <= 1'b1;
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= w_map ? io_cfg_pkg::RESP_OK : io_cfg_pkg::RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_full_reg   <= 1'b0;
				w_full_reg    <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// register writes; the differential block keeps only eight channels [RULE21]
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg     <= io_cfg_pkg::CTRL_RST;
			dc_samp_reg  <= io_cfg_pkg::DC_SAMP_DEF;
			dc_upd_reg   <= io_cfg_pkg::DC_UPD_DEF;
			filt_sel_reg <= io_cfg_pkg::FILT_SEL_DEF;
			diff_upd_reg <= io_cfg_pkg::DIFF_UPD_DEF;
			log_per_reg  <= io_cfg_pkg::LOG_PER_DEF;
			post_reg     <= io_cfg_pkg::POST_DEF;
			out_src_reg  <= 32'h0000_0000;
			diff_cfg_reg <= io_cfg_pkg::DIFF_CFG_RST;
			rem_dc_reg   <= 32'h0000_0000;
			rem_diff_reg <= 10'h000;
			for (int i = 0; i < io_cfg_pkg::N_FILT; i++) begin
				lim_reg[i] <= (i < io_cfg_pkg::N_DC) ? io_cfg_pkg::LIM_DC_DEF
					: io_cfg_pkg::LIM_DIFF_DEF; // [RULE7]
			end
		end else if (do_write && w_map) begin
			unique case (wa)
				io_cfg_pkg::CTRL_OFS: ctrl_reg <= {17'h0, wv_ctrl[14:0]};
				io_cfg_pkg::DC_SAMP_OFS: dc_samp_reg <= wv_any[15:0];
				io_cfg_pkg::DC_UPD_OFS: dc_upd_reg <= wv_any[15:0];
				io_cfg_pkg::DIFF_FILT_OFS: filt_sel_reg <= wv_any[3:0];
				io_cfg_pkg::DIFF_UPD_OFS: diff_upd_reg <= wv_any[15:0];
				io_cfg_pkg::LOG_PER_OFS: log_per_reg <= wv_any[15:0];
				io_cfg_pkg::POST_TRIG_OFS: post_reg <= wv_any[18:0];
				io_cfg_pkg::OUT_SRC_OFS: out_src_reg <= wv_any;
				io_cfg_pkg::DIFF_CFG_OFS: diff_cfg_reg <= wv_any[23:0];
				io_cfg_pkg::REM_DC_OFS: rem_dc_reg <= wv_any;
				io_cfg_pkg::REM_DIFF_OFS: rem_diff_reg <= wv_any[9:0];
				default: lim_reg[wl[7:2]] <= wv_any[11:0]; // [RULE7]
			endcase
		end
	end

	// effective settings
	wire ext_rst_on = ctrl_reg[io_cfg_pkg::C_EXT_RST];
	wire run        = ctrl_reg[io_cfg_pkg::C_RUN];
	wire log_en     = ctrl_reg[io_cfg_pkg::C_LOG_EN];
	wire dir_user   = ctrl_reg[io_cfg_pkg::C_DIR_SRC]; // [RULE11]
	// logging options fall back to defaults while logging is off [RULE22]
	wire trig_mode  = log_en && ctrl_reg[io_cfg_pkg::C_TRIG]; // [RULE13]
	wire ring_mode  = log_en && ctrl_reg[io_cfg_pkg::C_RING]; // [RULE14]
	wire start_reg_src = log_en && ctrl_reg[io_cfg_pkg::C_START]; // [RULE15]
	wire strobe_user = log_en && ctrl_reg[io_cfg_pkg::C_STROBE]; // [RULE16]
	wire tdiv       = log_en && ctrl_reg[io_cfg_pkg::C_TDIV]; // [RULE19]
	wire [3:0] dcode_raw = ctrl_reg[io_cfg_pkg::C_DEPTH +: 4];
	wire [3:0] dcode = (!log_en || dcode_raw > io_cfg_pkg::DEPTH_MAX) ?
		io_cfg_pkg::DEPTH_DEF : dcode_raw; // [RULE17]
	wire [19:0] depth = 20'(20'h1 << (5'(dcode) + 5'(io_cfg_pkg::DEPTH_MIN_LOG2)));
	wire [18:0] last_addr = 19'(depth - 20'h1);
	// post count: 1 outside trigger mode, clamped to 1..depth-1 [RULE18] [RULE22]
	wire [18:0] post_eff = !trig_mode ? io_cfg_pkg::POST_DEF :
		(post_reg == 19'h0) ? io_cfg_pkg::POST_DEF :
		(post_reg > last_addr) ? last_addr : post_reg;

	// stop choices forced to high unless allowed (external reset off; rs-485 also user direction) and not code 3 [RULE10] [RULE12]
	function automatic logic [1:0] stop_eff(input logic allow, input logic [1:0] code);
		return (allow && code != 2'h3) ? code : io_cfg_pkg::STOP_HIGH;
	endfunction : stop_eff

	// timing generators
	wire [16:0] dc_samp_v = (dc_samp_reg < io_cfg_pkg::DC_SAMP_MIN) ?
		17'(io_cfg_pkg::DC_SAMP_MIN) : {1'b0, dc_samp_reg};
	wire [16:0] dc_upd_v = (dc_upd_reg < io_cfg_pkg::DC_SAMP_MIN) ?
		17'(io_cfg_pkg::DC_SAMP_MIN) : {1'b0, dc_upd_reg};
	wire [16:0] diff_upd_v = (diff_upd_reg == 16'h0) ? 17'h1 : {1'b0, diff_upd_reg};
	wire [3:0]  fsel = (filt_sel_reg > io_cfg_pkg::FILT_SEL_MAX) ?
		io_cfg_pkg::FILT_SEL_DEF : filt_sel_reg;
	wire [16:0] log_us = (log_per_reg == 16'h0) ? 17'h10000 : {1'b0, log_per_reg};
	logic [20:0] tper [5];
	logic [4:0]  tick;
	assign tper[0] = steps_to_cyc(dc_samp_v); // [RULE2] [RULE4]
	assign tper[1] = steps_to_cyc(dc_upd_v); // [RULE5]
	assign tper[2] = steps_to_cyc(filt_steps(fsel)); // [RULE3]
	assign tper[3] = steps_to_cyc(diff_upd_v); // [RULE5]
	assign tper[4] = 21'(log_us * 21'(LOG_CYC_PER_US)); // [RULE6]

	generate
		for (genvar t = 0; t < 5; t++) begin : g_tmr
			logic [20:0] cnt_reg;
			wire         wrap = (cnt_reg + 21'h1 >= tper[t]);
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					cnt_reg <= 21'h0;
					tick[t] <= 1'b0;
				end else begin
					cnt_reg <= wrap ? 21'h0 : cnt_reg + 21'h1;
					tick[t] <= wrap;
				end
			end
		end
	endgenerate

	// input filters: dc on the dc sample tick, differential on its filter tick
	wire [40:0] fin = {rs485_in, diff_in, dc_in};
	logic [40:0] fout;
	generate
		for (genvar c = 0; c < io_cfg_pkg::N_FILT; c++) begin : g_flt
			input_filter u_flt (
				.clk_sys (clk_sys),
				.nrst    (nrst),
				.strobe  ((c < io_cfg_pkg::N_DC) ? tick[0] : tick[2]), // [RULE3] [RULE4]
				.din     (fin[c]),
				.limit   (lim_reg[c]),
				.dout    (fout[c])
			);
		end
	endgenerate
	assign dc_filt    = fout[31:0];
	assign diff_filt  = fout[39:32];
	assign rs485_filt = fout[40];

	// outputs
	wire [31:0] dc_sel = (out_src_reg & user_dc_out) | (~out_src_reg & rem_dc_reg); // [RULE8]
	wire [7:0]  diff_src = diff_cfg_reg[7:0];
	wire [7:0]  diff_sel = (diff_src & user_diff_out) | (~diff_src & rem_diff_reg[7:0]);
	wire        rs_dir = dir_user ? user_rs485_dir : ctrl_reg[io_cfg_pkg::C_DIR_OUT];
	wire        rs_dat = dir_user ? user_rs485_out : rem_diff_reg[8];
	wire [1:0]  rs_stop = stop_eff(!ext_rst_on && dir_user, diff_cfg_reg[9:8]);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dc_out      <= 32'h0000_0000;
			rs485_out   <= 1'b1;
			rs485_oe    <= 1'b0;
			board_reset <= 1'b1;
		end else begin
			board_reset <= !run && ext_rst_on; // [RULE1]
			if (run && tick[1]) begin
				dc_out <= dc_sel; // [RULE8]
			end else if (!run) begin
				dc_out <= 32'h0000_0000;
			end
			rs485_oe <= rs_dir; // [RULE11]
			if (run && tick[3]) begin
				rs485_out <= rs_dat;
			end else if (!run && rs_stop != io_cfg_pkg::STOP_HOLD) begin
				rs485_out <= (rs_stop == io_cfg_pkg::STOP_HIGH); // [RULE12] [RULE23]
			end
		end
	end

	generate
		for (genvar d = 0; d < io_cfg_pkg::N_DIFF; d++) begin : g_dout
			wire [1:0] st = stop_eff(!ext_rst_on, diff_cfg_reg[8 + 2*d +: 2]); // [RULE10]
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					diff_out[d] <= 1'b1;
				end else if (run && tick[3]) begin
					diff_out[d] <= diff_sel[d]; // [RULE8]
				end else if (!run && st != io_cfg_pkg::STOP_HOLD) begin
					diff_out[d] <= (st == io_cfg_pkg::STOP_HIGH); // [RULE9] [RULE23]
				end
			end
		end
	endgenerate

	// logging engine
	io_cfg_pkg::log_state_t lst_reg;
	io_cfg_pkg::log_state_t lst_next;
	logic [18:0] pcnt_reg;
	logic        wrapped_reg;
	wire lstart = start_reg_src ? rem_diff_reg[9] : user_log_start; // [RULE15]
	wire lstrb  = strobe_user ? user_log_strobe : tick[4]; // [RULE16]
	wire at_end = (log_addr == last_addr);
	wire full_stop = at_end && !ring_mode; // [RULE14]
	wire post_end = (pcnt_reg + 19'h1 >= post_eff);
	wire do_rec = lstrb && (lst_reg == io_cfg_pkg::LOG_RUN || lst_reg == io_cfg_pkg::LOG_POST);

	always_comb begin
		lst_next = lst_reg;
		unique case (lst_reg)
			io_cfg_pkg::LOG_IDLE: if (log_en && lstart) lst_next = io_cfg_pkg::LOG_RUN;
			io_cfg_pkg::LOG_RUN: begin
				if (!trig_mode && !lstart) lst_next = io_cfg_pkg::LOG_DONE;
				else if (lstrb && full_stop) lst_next = io_cfg_pkg::LOG_DONE;
				else if (trig_mode && user_log_trigger) lst_next = io_cfg_pkg::LOG_POST; // [RULE13]
			end
			io_cfg_pkg::LOG_POST: begin
				if (lstrb && (post_end || full_stop)) lst_next = io_cfg_pkg::LOG_DONE; // [RULE18]
			end
			io_cfg_pkg::LOG_DONE: if (!lstart) lst_next = io_cfg_pkg::LOG_IDLE;
		endcase
		if (!log_en) lst_next = io_cfg_pkg::LOG_IDLE;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lst_reg      <= io_cfg_pkg::LOG_IDLE;
			log_addr     <= 19'h0;
			pcnt_reg     <= 19'h0;
			wrapped_reg  <= 1'b0;
			log_wr       <= 1'b0;
			log_time_div <= 1'b0;
			user_sw_en   <= 1'b0;
		end else begin
			lst_reg      <= lst_next;
			log_wr       <= do_rec;
			log_time_div <= tdiv; // [RULE19]
			user_sw_en   <= ctrl_reg[io_cfg_pkg::C_USER_SW]; // [RULE20]
			if (lst_reg == io_cfg_pkg::LOG_IDLE && lst_next == io_cfg_pkg::LOG_RUN) begin
				log_addr    <= 19'h0;
				pcnt_reg    <= 19'h0;
				wrapped_reg <= 1'b0;
			end else if (do_rec) begin
				log_addr <= at_end ? 19'h0 : log_addr + 19'h1; // [RULE17]
				if (at_end) wrapped_reg <= 1'b1;
				if (lst_reg == io_cfg_pkg::LOG_POST) pcnt_reg <= pcnt_reg + 19'h1;
			end
		end
	end

	// read path
	always_comb begin
		r_map  = (ra[1:0] == 2'h0);
		r_word = 32'h0000_0000;
		unique case (ra)
			io_cfg_pkg::CTRL_OFS: r_word = ctrl_reg;
			io_cfg_pkg::DC_SAMP_OFS: r_word = {16'h0, dc_samp_reg};
			io_cfg_pkg::DC_UPD_OFS: r_word = {16'h0, dc_upd_reg};
			io_cfg_pkg::DIFF_FILT_OFS: r_word = {28'h0, filt_sel_reg};
			io_cfg_pkg::DIFF_UPD_OFS: r_word = {16'h0, diff_upd_reg};
			io_cfg_pkg::LOG_PER_OFS: r_word = {16'h0, log_per_reg};
			io_cfg_pkg::POST_TRIG_OFS: r_word = {13'h0, post_reg};
			io_cfg_pkg::OUT_SRC_OFS: r_word = out_src_reg;
			io_cfg_pkg::DIFF_CFG_OFS: r_word = {8'h0, diff_cfg_reg};
			io_cfg_pkg::REM_DC_OFS: r_word = rem_dc_reg;
			io_cfg_pkg::REM_DIFF_OFS: r_word = {22'h0, rem_diff_reg};
			io_cfg_pkg::STATUS_OFS: r_word = {8'h0, board_reset, wrapped_reg, lst_reg,
				1'b0, log_addr};
			default: begin
				r_map  = r_lim && (ra[1:0] == 2'h0);
				r_word = r_map ? {20'h0, lim_reg[rl[7:2]]} : 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= io_cfg_pkg::RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= r_word;
			s_axi_rresp   <= r_map ? io_cfg_pkg::RESP_OK : io_cfg_pkg::RESP_ERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : io_control_top
`default_nettype wire

// File: verif/io_control_monitor.sv
// port-level checker for the i/o control and logging block
`timescale 1ns/1ns
`default_nettype none
module io_control_monitor (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [31:0] dc_out,
	input wire logic [7:0]  diff_out,
	input wire logic        rs485_out,
	input wire logic        board_reset,
	input wire logic        log_wr,
	input wire logic [18:0] log_addr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	chk_dc_stop_zero: assert property (board_reset && $past(board_reset) |-> dc_out == 32'h0)
		else $error("dc outputs not cleared while board reset");
	chk_diff_stop_high: assert property (board_reset && $past(board_reset) |-> diff_out == 8'hFF)
		else $error("differential outputs not high while board reset");
	chk_rs485_stop_hi: assert property (board_reset && $past(board_reset) |-> rs485_out)
		else $error("rs485 output not high while board reset");
	chk_addr_step: assert property (log_wr && $past(log_wr) |-> log_addr == $past(log_addr) + 19'h1 || log_addr == 19'h0)
		else $error("log address did not step by one");
	chk_addr_moves: assert property ($changed(log_addr) |-> log_wr || log_addr == 19'h0)
		else $error("log address moved without a record");
	chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[0:1] s_axi_rvalid)
		else $error("read answer late");
endmodule : io_control_monitor
bind io_control_top io_control_monitor i_mon (.clk_sys(clk_sys), .nrst(nrst),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .dc_out(dc_out), .diff_out(diff_out),
	.rs485_out(rs485_out), .board_reset(board_reset), .log_wr(log_wr), .log_addr(log_addr));
`default_nettype wire

// File: verif/field_io_model.sv
// field wiring and user circuit stand-in
`timescale 1ns/1ns
`default_nettype none
module field_io_model (
	input  wire logic        rs485_out,
	input  wire logic        rs485_oe,
	output wire logic        rs485_in,
	output var  logic [31:0] dc_in,
	output var  logic [7:0]  diff_in,
	output var  logic [31:0] user_dc_out,
	output var  logic [8:0]  user_misc
);
	// loop back while the block drives, fail-safe idle high otherwise
	assign rs485_in = rs485_oe ? rs485_out : 1'b1;
	initial begin
		dc_in = 32'h0000_FFFF;
		diff_in = 8'h3C;
		user_dc_out = 32'h5A5A_F0F0;
		user_misc = 9'h000;
	end
endmodule : field_io_model
`default_nettype wire

// File: verif/io_control_logging_config_tb_top.sv
// self-checking bench for the i/o control and logging block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("BAD %s exp %0h got %0h", n, e, a); end end
module io_control_logging_config_tb_top;
	logic clk_sys = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd, rdata, dc_in, udc, dc_out, dcf;
	logic [1:0] bresp, rresp, resp;
	logic [8:0] um;
	logic [7:0] diff_in, diff_out;
	logic [18:0] log_addr;
	logic awready, wready, bvalid, arready, rvalid, rs_in, rs_out, rs_oe, brst, log_wr, tdiv, swen;
	int bad_count = 0, num_checks = 0, n_wr = 0, k, i;
	logic [7:0] ofs [5] = '{8'h04, 8'h14, 8'h18, 8'h40, 8'hC0};
	logic [31:0] exv [5] = '{32'hF, 32'h1, 32'h1, 32'hFA0, 32'h5DC};
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (log_wr === 1'b1) n_wr <= n_wr + 1;
	field_io_model i_fld (.rs485_out(rs_out), .rs485_oe(rs_oe), .rs485_in(rs_in), .dc_in(dc_in),
		.diff_in(diff_in), .user_dc_out(udc), .user_misc(um));
	io_control_top #(.LOG_CYC_PER_US(1)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .dc_in(dc_in), .diff_in(diff_in),
		.rs485_in(rs_in), .user_dc_out(udc), .user_diff_out(um[7:0]), .user_rs485_out(um[0]),
		.user_rs485_dir(um[1]), .user_log_start(um[8]), .user_log_strobe(um[7]),
		.user_log_trigger(um[6]), .dc_filt(dcf), .diff_filt(), .rs485_filt(), .dc_out(dc_out),
		.diff_out(diff_out), .rs485_out(rs_out), .rs485_oe(rs_oe), .board_reset(brst),
		.log_wr(log_wr), .log_addr(log_addr), .log_time_div(tdiv), .user_sw_en(swen));
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge clk_sys);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (k == 100) begin bad_count++; report_and_stop(); end
	endtask : axi_wr
	task axi_rd(input logic [7:0] a);
		araddr <= a; arvalid <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge clk_sys);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rd = rdata; resp = rresp;
		if (k == 100) begin bad_count++; report_and_stop(); end
	endtask : axi_rd
	initial begin
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		`CHK("board_reset", 1'b1, brst)
		axi_rd(io_cfg_pkg::CTRL_OFS); `CHK("ctrl", io_cfg_pkg::CTRL_RST, rd)
		for (i = 0; i < 5; i++) begin axi_rd(ofs[i]); `CHK("default", exv[i], rd) end
		axi_rd(8'hFC); `CHK("unmapped", io_cfg_pkg::RESP_ERR, resp)
		axi_wr(io_cfg_pkg::LIMIT_OFS, 32'h0); repeat (20) @(posedge clk_sys);
		`CHK("dc_filt0", 1'b1, dcf[0])
		axi_wr(io_cfg_pkg::REM_DC_OFS, 32'hA5A5_0F0F);
		axi_wr(io_cfg_pkg::OUT_SRC_OFS, 32'hFFFF_0000);
		axi_wr(io_cfg_pkg::CTRL_OFS, 32'h0000_0803);
		repeat (20) @(posedge clk_sys);
		`CHK("dc_out", 32'h5A5A_0F0F, dc_out)
		`CHK("board_reset", 1'b0, brst)
		axi_wr(io_cfg_pkg::DIFF_CFG_OFS, 32'h0055_6400);
		axi_wr(io_cfg_pkg::REM_DIFF_OFS, 32'h0000_0005);
		axi_wr(io_cfg_pkg::CTRL_OFS, 32'h0000_0802);
		repeat (5) @(posedge clk_sys); `CHK("diff_out", 8'h05, diff_out)
		axi_wr(io_cfg_pkg::CTRL_OFS, 32'h0000_0800);
		repeat (3) @(posedge clk_sys); `CHK("diff_stop", 8'hFE, diff_out)
		`CHK("board_reset", 1'b0, brst)
		axi_wr(io_cfg_pkg::CTRL_OFS, 32'h0000_0801);
		repeat (3) @(posedge clk_sys); `CHK("diff_forced", 8'hFF, diff_out)
		i_fld.user_misc[8] <= 1'b1;
		axi_wr(io_cfg_pkg::CTRL_OFS, 32'h0000_41C6);
		repeat (10) @(posedge clk_sys);
		`CHK("dir_out", 1'b1, rs_oe)
		`CHK("tdiv", 1'b1, tdiv)
		`CHK("sw_en", 1'b1, swen)
		`CHK("no_timer", 0, n_wr)
		i_fld.user_misc[7] <= 1'b1;
		repeat (3) @(posedge clk_sys);
		i_fld.user_misc[7] <= 1'b0;
		repeat (5) @(posedge clk_sys);
		`CHK("records", 3, n_wr)
		`CHK("log_addr", 19'h3, log_addr)
		report_and_stop();
	end
endmodule : io_control_logging_config_tb_top
`default_nettype wire
